// ### rtl/imc_master.sv
// two-wire bus master controller: bit sequencer, status flags, read word assembly
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module imc_master #(
    parameter int DATA_WIDTH = 8,
    parameter int FIFO_DEPTH = imc_pkg::RX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    // user control
    input wire logic soft_rst,
    input wire logic arb_clr,
    input wire imc_pkg::imc_req_type req,
    input wire logic [DATA_WIDTH-1:0] wr_data,
    // user status and read data
    output imc_pkg::imc_stat_type stat,
    output logic [DATA_WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_taken
);
    import imc_pkg::*;
    localparam int NB = DATA_WIDTH / 8;
    localparam int BW = $clog2(NB + 1);
    localparam logic [BW-1:0] NB_W = BW'(NB);

    typedef struct packed {
        imc_state_type state;
        logic [1:0] phase;
        logic [3:0] bitn;
        logic [QW-1:0] qcnt;
        logic [QW-1:0] qlen;
        imc_kind_type kind;
        logic rd_dir;
        logic keep;
        logic [7:0] shreg;
        logic [7:0] left;
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [DATA_WIDTH-1:0] wword;
        logic [BW-1:0] widx;
        logic need_load;
        logic scl_drv;
        logic sda_drv;
        logic line_busy;
        logic scl_d;
        logic sda_d;
        logic arb_lost;
        logic nack;
        logic wdone;
        logic push_v;
        logic push_last;
        logic [DATA_WIDTH-1:0] acc;
        logic [BW-1:0] acnt;
        logic acc_full;
        logic [DATA_WIDTH-1:0] rdat;
        logic rval;
    } imc_core_type;

    imc_core_type r;
    imc_core_type n;
    logic scl_f;
    logic sda_f;
    logic arb_set;
    logic take;
    logic load_w;
    logic fin;
    logic tx;
    logic tick;
    logic [DATA_WIDTH-1:0] src;
    logic fifo_in_ready;
    logic fo_valid;
    imc_rxb_type fi;
    imc_rxb_type fo;

    ////////////////////////////////////////////////////////////////////////////
    imc_filter u_scl_filt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .line_in(scl_in),
        .line_out(scl_f)
    );

    imc_filter u_sda_filt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .line_in(sda_in),
        .line_out(sda_f)
    );

    // received bytes queue here; when full, the bus clock is held low
    assign fi = '{last: r.push_last, data: r.shreg};

    imc_fifo #(
        .WIDTH($bits(imc_rxb_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(r.push_v),
        .in_data(fi),
        .in_ready(fifo_in_ready),
        .out_valid(fo_valid),
        .out_data(fo),
        .out_ready(!r.acc_full)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        arb_set = 1'b0;
        take = 1'b0;
        load_w = 1'b0;
        fin = 1'b0;
        tx = (r.kind != K_RDATA);
        tick = (r.qcnt == '0);
        src = r.need_load ? wr_data : r.wword;
        n.wdone = 1'b0;
        n.scl_d = scl_f;
        n.sda_d = sda_f;
        if (!tick) begin
            n.qcnt = r.qcnt - 1'b1;
        end
        if (r.push_v && fifo_in_ready) begin
            n.push_v = 1'b0;
        end
        // START and STOP on the lines, whoever made them
        if (scl_f && r.scl_d && r.sda_d && !sda_f) begin
            n.line_busy = 1'b1;
        end
        if (scl_f && r.scl_d && !r.sda_d && sda_f) begin
            n.line_busy = 1'b0;
        end
        unique case (r.state)
            ST_IDLE: begin
                take = (req.write || req.read) && !r.line_busy;
            end
            ST_HOLD: begin
                take = req.write || req.read;
            end
            ST_START: begin
                if (r.phase == 2'h1 && !scl_f) begin
                    n.qcnt = r.qlen;
                end else if (tick) begin
                    n.qcnt = r.qlen;
                    n.phase = r.phase + 2'h1;
                    if (r.phase == 2'h0) begin
                        n.scl_drv = 1'b0;
                    end else if (r.phase == 2'h1) begin
                        // data already low here means another master owns the bus
                        arb_set = !sda_f;
                        n.sda_drv = 1'b1;
                    end else begin
                        n.scl_drv = 1'b1;
                        n.state = ST_BYTE;
                        n.phase = 2'h0;
                        n.bitn = 4'h0;
                        n.kind = K_ADDR;
                        n.shreg = {r.addr[7:1], r.rd_dir};
                    end
                end
            end
            ST_BYTE: begin
                unique case (r.phase)
                    2'h0: begin
                        // a pending byte the fifo cannot take stretches the low phase
                        if (tick && !r.push_v) begin
                            n.qcnt = r.qlen;
                            n.phase = 2'h1;
                            if (r.bitn != 4'h8) begin
                                n.sda_drv = tx && !r.shreg[7];
                            end else begin
                                n.sda_drv = !tx && (r.left != 8'h01);
                            end
                        end
                    end
                    2'h1: begin
                        if (tick) begin
                            n.qcnt = r.qlen;
                            n.phase = 2'h2;
                            n.scl_drv = 1'b0;
                        end
                    end
                    2'h2: begin
                        if (!scl_f) begin
                            n.qcnt = r.qlen;
                        end else if (tick) begin
                            n.qcnt = r.qlen;
                            n.phase = 2'h3;
                            if (r.bitn == 4'h8) begin
                                if (tx) begin
                                    n.nack = sda_f;
                                end
                            end else if (tx) begin
                                arb_set = !r.sda_drv && !sda_f;
                                n.shreg = {r.shreg[6:0], 1'b0};
                            end else begin
                                n.shreg = {r.shreg[6:0], sda_f};
                            end
                        end
                    end
                    2'h3: begin
                        if (tick) begin
                            n.qcnt = r.qlen;
                            n.phase = 2'h0;
                            n.scl_drv = 1'b1;
                            if (r.bitn != 4'h8) begin
                                n.bitn = r.bitn + 4'h1;
                                if (r.bitn == 4'h7 && !tx) begin
                                    n.push_v = 1'b1;
                                    n.push_last = (r.left == 8'h01);
                                end
                            end else begin
                                n.bitn = 4'h0;
                                unique case (r.kind)
                                    K_ADDR: begin
                                        if (r.nack || (r.rd_dir && r.left == 8'h00)) begin
                                            fin = 1'b1;
                                        end else if (r.rd_dir) begin
                                            n.kind = K_RDATA;
                                        end else begin
                                            n.kind = K_CMD;
                                            n.shreg = r.cmd;
                                        end
                                    end
                                    K_CMD: begin
                                        fin = r.nack || (r.left == 8'h00);
                                        load_w = !fin;
                                    end
                                    K_WDATA: begin
                                        n.left = r.left - 8'h01;
                                        n.wdone = (r.widx == NB_W) || (r.left == 8'h01);
                                        fin = r.nack || (r.left == 8'h01);
                                        load_w = !fin;
                                    end
                                    K_RDATA: begin
                                        n.left = r.left - 8'h01;
                                        fin = (r.left == 8'h01);
                                    end
                                endcase
                            end
                        end
                    end
                endcase
            end
            ST_STOP: begin
                if (r.phase == 2'h2 && !scl_f) begin
                    n.qcnt = r.qlen;
                end else if (tick) begin
                    n.qcnt = r.qlen;
                    n.phase = r.phase + 2'h1;
                    if (r.phase == 2'h0) begin
                        n.sda_drv = 1'b1;
                    end else if (r.phase == 2'h1) begin
                        n.scl_drv = 1'b0;
                    end else if (r.phase == 2'h2) begin
                        n.sda_drv = 1'b0;
                    end else begin
                        n.state = ST_IDLE;
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        // payload words go out low byte first; a fresh word is fetched at the same edge that raises write done
        if (load_w) begin
            n.kind = K_WDATA;
            n.shreg = src[7:0];
            n.wword = src >> 8;
            n.widx = (r.need_load ? '0 : r.widx) + 1'b1;
            n.need_load = (n.widx == NB_W);
        end
        // a kept bus holds the clock low and resumes with a repeated START
        if (fin) begin
            if (r.keep && !r.nack) begin
                n.state = ST_HOLD;
                n.sda_drv = 1'b0;
            end else begin
                n.state = ST_STOP;
                n.phase = 2'h0;
            end
        end
        if (take) begin
            n.state = ST_START;
            n.phase = 2'h0;
            n.qlen = req.fast ? QTR_FAST_CYC : QTR_STD_CYC;
            n.qcnt = n.qlen;
            n.rd_dir = !req.write;
            n.keep = req.keep_bus;
            n.addr = req.target;
            n.cmd = req.cmd;
            n.left = req.count;
            n.wword = wr_data;
            n.widx = '0;
            n.need_load = 1'b0;
            n.nack = 1'b0;
        end
        if (arb_set) begin
            n.state = ST_IDLE;
            n.scl_drv = 1'b0;
            n.sda_drv = 1'b0;
        end
        // a loss in the clearing cycle still sets the flag
        n.arb_lost = arb_set || (r.arb_lost && !arb_clr);
        if (soft_rst) begin
            n.state = ST_IDLE;
            n.phase = 2'h0;
            n.scl_drv = 1'b0;
            n.sda_drv = 1'b0;
            n.line_busy = 1'b0;
            n.push_v = 1'b0;
        end
        // read word assembly: newest byte enters at the top, older ones shift down
        if (fo_valid && !r.acc_full) begin
            n.acc = DATA_WIDTH'({fo.data, r.acc} >> 8);
            n.acnt = r.acnt + 1'b1;
            n.acc_full = fo.last || (n.acnt == NB_W);
        end
        if (r.acc_full && (!r.rval || rd_taken)) begin
            n.rdat = r.acc;
            n.rval = 1'b1;
            n.acc_full = 1'b0;
            n.acnt = '0;
        end else if (rd_taken) begin
            n.rval = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = r.scl_drv;
    assign sda_oe = r.sda_drv;
    assign stat = '{busy: (r.state != ST_IDLE) || r.line_busy,
                    arb_lost: r.arb_lost,
                    nack: r.nack,
                    write_done: r.wdone};
    assign rd_data = r.rdat;
    assign rd_valid = r.rval;

    ////////////////////////////////////////////////////////////////////////////
    rate_sel_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (r.state != ST_IDLE) |-> (r.qlen == QTR_STD_CYC || r.qlen == QTR_FAST_CYC))
        else $error("quarter length is neither bus rate");

    clock_stretch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (r.state == ST_BYTE && r.phase == 2'h2 && !scl_f && !soft_rst)
        |=> (r.phase == 2'h2 && r.qcnt == r.qlen && !scl_oe))
        else $error("high phase advanced while the clock was held low");

    arb_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        arb_set |=> (r.state == ST_IDLE && !scl_oe && !sda_oe && stat.arb_lost))
        else $error("lines not released after arbitration loss");

    header_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (r.state == ST_START && r.phase == 2'h2 && tick && !soft_rst && !arb_set)
        |=> (r.kind == K_ADDR && r.shreg == {r.addr[7:1], r.rd_dir}))
        else $error("header byte not address with direction bit");

    busy_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (r.state != ST_IDLE) |-> stat.busy)
        else $error("busy low during a transfer");

    arb_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (stat.arb_lost && !arb_clr) |=> stat.arb_lost)
        else $error("arbitration flag dropped without a clear");

    arb_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (arb_clr && !arb_set) |=> !stat.arb_lost)
        else $error("arbitration flag survived its clear");

    ack_status_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (r.state == ST_BYTE && r.phase == 2'h2 && r.bitn == 4'h8 && tx && scl_f && tick
         && !take) |=> (stat.nack == $past(sda_f)))
        else $error("nack status does not match the sampled acknowledge");

    write_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        stat.write_done |-> ($past(r.kind) == K_WDATA) ##1 !stat.write_done)
        else $error("write done not a single pulse after a payload byte");

    read_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_valid && !rd_taken) |=> (rd_valid && $stable(rd_data)))
        else $error("read data changed before it was taken");

    soft_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        soft_rst |=> (r.state == ST_IDLE && !scl_oe && !sda_oe && !r.line_busy))
        else $error("soft reset did not idle the bus side");

    idle_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (r.state == ST_IDLE) |-> (!scl_oe && !sda_oe && !scl_out && !sda_out))
        else $error("a line is driven while idle");
endmodule
`default_nettype wire

// ### rtl/imc_pkg.sv
// shared constants and types of the two-wire bus master controller
package imc_pkg;
    localparam int CLK_NS = 4;
    // a bit is four quarters; quarter lengths for 100 kHz and 400 kHz
    localparam int QTR_STD_NS = 2500;
    localparam int QTR_FAST_NS = 625;
    localparam int QW = 10;
    localparam logic [QW-1:0] QTR_STD_CYC = QW'((QTR_STD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [QW-1:0] QTR_FAST_CYC = QW'((QTR_FAST_NS + CLK_NS - 1) / CLK_NS);
    // spikes shorter than this are ignored on both lines
    localparam int FILT_NS = 50;
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RX_FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_BYTE = 3'h2,
        ST_STOP = 3'h3,
        ST_HOLD = 3'h4
    } imc_state_type;

    typedef enum logic [1:0] {
        K_ADDR = 2'h0,
        K_CMD = 2'h1,
        K_WDATA = 2'h2,
        K_RDATA = 2'h3
    } imc_kind_type;

    typedef struct packed {
        logic write;
        logic read;
        logic keep_bus;
        logic fast;
        logic [7:0] target;
        logic [7:0] cmd;
        logic [7:0] count;
    } imc_req_type;

    typedef struct packed {
        logic busy;
        logic arb_lost;
        logic nack;
        logic write_done;
    } imc_stat_type;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } imc_rxb_type;
endpackage

// ### rtl/imc_filter.sv
// two-flop synchroniser and spike filter for one bus line
`timescale 1ns/1ns
`default_nettype none
module imc_filter #(
    parameter int CYC = imc_pkg::FILT_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // raw line and its filtered level
    input wire logic line_in,
    output logic line_out
);
    import imc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [7:0] cnt;
    } imc_filt_type;

    imc_filt_type r;
    imc_filt_type n;

    // a new level must hold for CYC cycles before it is believed
    always_comb begin
        n = r;
        n.s1 = line_in;
        n.s2 = r.s1;
        if (r.s2 == r.lvl) begin
            n.cnt = 8'h00;
        end else if (r.cnt == 8'(CYC - 1)) begin
            n.lvl = r.s2;
            n.cnt = 8'h00;
        end else begin
            n.cnt = r.cnt + 8'h01;
        end
    end

    // idle bus lines float high
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: 8'h00};
        end else begin
            r <= n;
        end
    end

    assign line_out = r.lvl;
endmodule
`default_nettype wire

// ### rtl/imc_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module imc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = imc_pkg::RX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    import imc_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } imc_fifo_type;

    imc_fifo_type r;
    imc_fifo_type n;
    logic push;
    logic pop;

    assign in_ready = (r.cnt != FULL);
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];

    always_comb begin
        n = r;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            n.mem[r.wp] = in_data;
            n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
        end
        n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    fifo_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (push && !pop) |=> (r.cnt == $past(r.cnt) + 1'b1))
        else $error("fifo count did not rise on a lone push");

    fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (r.cnt == FULL) |-> !in_ready ##1 (r.cnt <= FULL))
        else $error("fifo overfilled");
endmodule
`default_nettype wire

// ### tb/imc_target.sv
// target model on the two-wire bus: acks its address, reads return RDATA
`timescale 1ns/1ns
`default_nettype none
module imc_target #(
    parameter logic [6:0] ADDR = 7'h2A,
    parameter logic [7:0] RDATA = 8'hC3
) (
    // bus lines
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    // last four bytes on the bus, newest lowest, and the count of bytes since the last start
    output logic [31:0] seen,
    output logic [7:0] nb
);
    logic [3:0] cnt;
    logic [7:0] sr;
    logic rd, hit, mack;
    initial {cnt, nb, hit, rd, mack, sda_pull} = 16'h0002;
    // count starts one below zero: the clock fall that closes a START is not a bit
    always @(negedge sda) if (scl === 1'b1) {cnt, nb, hit, rd, mack} = 15'h7801;
    always @(posedge scl) begin
        if (cnt < 8) sr = {sr[6:0], sda};
        else mack = !sda;
    end
    always @(negedge scl) begin
        cnt = cnt + 4'h1;
        if (cnt == 8) begin
            if (nb == 0) {rd, hit} = {sr[0], sr[7:1] == ADDR};
            seen = {seen[23:0], sr};
            nb = nb + 8'h01;
            // the ack slot of a read byte belongs to the master
            sda_pull = hit && !(rd && nb > 1);
        end else begin
            if (cnt == 9) cnt = 0;
            // after a master nack the line stays free for its stop
            sda_pull = hit && rd && nb > 0 && mack && !RDATA[7 - cnt];
        end
    end
endmodule
`default_nettype wire

// ### tb/imc_master_tb.sv
// bench: two-wire bus master against one target model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin \
    num_checks++; \
    if ((a) !== (b)) n_fail++; \
    if ((a) !== (b)) $display("MISMATCH %0t %h %h", $time, a, b); \
end
module imc_master_tb;
    import imc_pkg::*;
    logic sys_clk = 0, reset_n = 0, arb_clr = 0, other = 0, rd_valid, soft_rst = 0;
    logic scl_oe, sda_oe, tsda, scl_o, sda_o;
    logic [7:0] wr_data = 8'h96, rd_data, lastw, nb, nw = 0;
    logic [31:0] seen;
    imc_req_type req = '0;
    imc_stat_type stat;
    int n_fail = 0, num_checks = 0, dones;
    wire scl = !scl_oe;
    wire sda = !(sda_oe | tsda | other);
    imc_master dut (.sys_clk, .reset_n, .scl_in(scl), .sda_in(sda), .scl_out(scl_o), .scl_oe,
        .sda_out(sda_o), .sda_oe, .soft_rst, .arb_clr, .req, .wr_data, .stat, .rd_data,
        .rd_valid, .rd_taken(1'b1));
    imc_target tgt (.scl(scl), .sda(sda), .sda_pull(tsda), .seen(seen), .nb(nb));
    always #2 sys_clk = ~sys_clk;
    // taken at once, so each cycle of valid is a new word
    always @(negedge sys_clk) if (rd_valid === 1'b1) {nw, lastw} = {nw + 8'h01, rd_data};
    initial begin
        #360000;
        n_fail++;
        end_sim();
    end
    task automatic end_sim();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // requests while busy are dropped silently except in the kept hold, so wait for a free bus first
    task automatic xfer(input logic w, f, input logic [7:0] t, c, n);
        int k;
        while (stat.busy !== 1'b0) @(negedge sys_clk);
        req = {w, !w, 1'b0, f, t, c, n};
        @(negedge sys_clk) req = {2'b00, req[25:0]};
        @(negedge sys_clk) dones = 0;
        `CHK(stat.busy, 1'b1)
        for (k = 0; k < 40000 && stat.busy !== 1'b0; k++)
            @(negedge sys_clk) dones += (stat.write_done === 1'b1);
        `CHK(stat.busy, 1'b0)
    endtask
    // soft reset in mid header to an absent target, which never pulls a line
    task automatic soft_check();
        while (stat.busy !== 1'b0) @(negedge sys_clk);
        req = {1'b1, 1'b0, 1'b0, 1'b1, 8'h40, 8'h11, 8'h01};
        @(negedge sys_clk) req = '0;
        repeat (2000) @(negedge sys_clk);
        `CHK(stat.busy, 1'b1)
        soft_rst = 1;
        @(negedge sys_clk) soft_rst = 0;
        `CHK({stat.busy, scl_oe, sda_oe, scl_o, sda_o}, 5'h00)
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        reset_n = 1;
        repeat (20) @(negedge sys_clk);
        xfer(1, 1, 8'h55, 8'h3C, 8'h01);
        `CHK({seen[23:0], nb, dones[1:0], stat.nack, stat.arb_lost}, 36'h543C96034)
        xfer(0, 1, 8'h54, 8'h00, 8'h02);
        `CHK({seen[23:16], nw, lastw, stat.nack}, {24'h5502C3, 1'b0})
        xfer(1, 0, 8'h40, 8'h11, 8'h01);
        `CHK({seen[7:0], nb, stat.nack}, {16'h4001, 1'b1})
        fork
            xfer(1, 1, 8'hFE, 8'h00, 8'h00);
            begin
                // a second master holds the data line low over our first header bit
                wait (scl_oe === 1'b1) @(negedge sys_clk) other = 1;
                wait (stat.arb_lost === 1'b1);
                // the other master ends with a STOP once the clock line has settled high
                repeat (30) @(negedge sys_clk);
                other = 0;
            end
        join
        `CHK(stat.arb_lost, 1'b1)
        arb_clr = 1;
        @(negedge sys_clk) arb_clr = 0;
        `CHK(stat.arb_lost, 1'b0)
        soft_check();
        end_sim();
    end
endmodule
`default_nettype wire
